/* File: logic/pmc_basic_ctrl.sv */
`timescale 1ns/100ps
`include "pmc_cfg.svh"
module pmc_basic_ctrl
  import pmc_pkg::*;
#(
  parameter int LB_DEAD_CYCLES = `PMC_LB_DEAD_CYC,
  parameter int SRST_CYCLES    = `PMC_SRST_CYC
) (
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RESETN,
  // Register port
  input  wire logic [4:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic       REG_RD,
  output logic     [15:0] REG_RDATA,
  output logic            REG_RVALID,
  // Strap pins
  input  wire logic       STRAP_AN_EN,
  input  wire logic       STRAP_SPEED_100,
  input  wire logic       STRAP_FULL_DUPLEX,
  // MII transmit pins
  input  wire logic       MII_TX_EN,
  input  wire logic [3:0] MII_TXD,
  // Line side receive
  input  wire logic [3:0] LINE_RXD,
  input  wire logic       LINE_RX_DV,
  input  wire logic       LINE_COL,
  // Auto-negotiation engine
  input  wire logic       AN_SPEED_100,
  input  wire logic       AN_FULL_DUPLEX,
  input  wire logic       AN_STARTED,
  output logic            AN_ENABLE,
  output logic            AN_RESTART,
  // Port mode
  output logic            SPEED_100,
  output logic            FULL_DUPLEX,
  output logic            POWER_DOWN,
  output logic            SOFT_RESET,
  // MII receive pins
  output logic            MII_OE,
  output logic     [3:0] MII_RXD,
  output logic            MII_RX_DV,
  output logic            MII_COL
);
  localparam int TCW         = $clog2(LB_DEAD_CYCLES + SRST_CYCLES + 1);
  localparam int COL_ON_MAX  = `PMC_COL_ON_CYC;
  localparam int COL_OFF_MAX = `PMC_COL_OFF_CYC;

  // Pin synchroniser: straps and MII transmit
  logic [7:0] pin_m_ff;
  logic [7:0] pin_s_ff;
  wire  [7:0] pins = {STRAP_AN_EN, STRAP_SPEED_100, STRAP_FULL_DUPLEX, MII_TX_EN, MII_TXD};

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pin_m_ff <= 8'h00;
      pin_s_ff <= 8'h00;
    end else begin
      pin_m_ff <= pins;
      pin_s_ff <= pin_m_ff;
    end
  end

  wire       strap_an  = pin_s_ff[7];
  wire       strap_spd = pin_s_ff[6];
  wire       strap_dup = pin_s_ff[5];
  wire       tx_en_s   = pin_s_ff[4];
  wire [3:0] tx_d_s    = pin_s_ff[3:0];

  // Strap capture waits for the synchroniser to fill after reset release
  logic [1:0] boot_cnt_ff;
  wire        boot_done = (boot_cnt_ff == 2'h0);
  wire        boot_load = (boot_cnt_ff == 2'h1);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      boot_cnt_ff <= `PMC_BOOT_CYC;
    end else if (!boot_done) begin
      boot_cnt_ff <= boot_cnt_ff - 2'h1;
    end
  end

  // Timers
  pmc_tmr_if srst_t();
  pmc_tmr_if lb_t();

  pmc_timer #(
    .CW   (TCW),
    .LOAD (TCW'(SRST_CYCLES))
  ) u_srst_tmr (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .t     (srst_t.tmr)
  );

  pmc_timer #(
    .CW   (TCW),
    .LOAD (TCW'(LB_DEAD_CYCLES))
  ) u_lb_tmr (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .t     (lb_t.tmr)
  );

  // Control register state
  pmc_srst_t state_ff;
  pmc_srst_t nxt_state;
  logic      loop_ff;
  logic      spd_ff;
  logic      an_ff;
  logic      pd_ff;
  logic      iso_ff;
  logic      restart_ff;
  logic      dup_ff;
  logic      col_ff;

  // Decode; writes during a reset sequence are dropped
  wire        addr_hit = (REG_ADDR == `PMC_BMC_OFFSET);
  wire        srst_idle = (state_ff == SR_IDLE);
  wire        wr_hit = REG_WR & addr_hit & srst_idle & boot_done;
  wire [15:0] wd = REG_WDATA;
  wire        load_cfg = boot_load | (state_ff == SR_RESTRAP);
  wire        srst_req = wr_hit & wd[`PMC_B_SRST];
  wire        rst_set = wr_hit & wd[`PMC_B_RESTART] & wd[`PMC_B_AN_EN];
  wire        lb_start = wr_hit & wd[`PMC_B_LOOP] & ~loop_ff;

  assign srst_t.start = srst_req;
  assign lb_t.start   = lb_start;

  always_comb begin
    case (state_ff)
      SR_IDLE:    nxt_state = srst_req ? SR_BUSY : SR_IDLE;
      SR_BUSY:    nxt_state = srst_t.done ? SR_RESTRAP : SR_BUSY;
      SR_RESTRAP: nxt_state = SR_IDLE;
      default:    nxt_state = SR_IDLE;
    endcase
  end

  // Next field values
  wire nxt_loop = load_cfg ? 1'b0 : (wr_hit ? wd[`PMC_B_LOOP] : loop_ff);
  wire nxt_pd   = load_cfg ? 1'b0 : (wr_hit ? wd[`PMC_B_PDOWN] : pd_ff);
  wire nxt_iso  = load_cfg ? 1'b0 : (wr_hit ? wd[`PMC_B_ISO] : iso_ff);
  wire nxt_col  = load_cfg ? 1'b0 : (wr_hit ? wd[`PMC_B_COLTEST] : col_ff);
  wire nxt_an   = load_cfg ? strap_an : (wr_hit ? wd[`PMC_B_AN_EN] : an_ff);
  wire nxt_spd  = load_cfg ? strap_spd : (wr_hit ? wd[`PMC_B_SPEED] : spd_ff);
  wire nxt_dup  = load_cfg ? strap_dup : (wr_hit ? wd[`PMC_B_DUPLEX] : dup_ff);
  // A new request wins over the engine's acknowledge; a zero write changes nothing
  wire nxt_restart = load_cfg ? 1'b0 :
                     (rst_set ? 1'b1 : (AN_STARTED ? 1'b0 : restart_ff));

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= SR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      {loop_ff, spd_ff, an_ff, pd_ff, iso_ff, restart_ff, dup_ff, col_ff} <= 8'h00;
    end else begin
      loop_ff    <= nxt_loop;
      spd_ff     <= nxt_spd;
      an_ff      <= nxt_an;
      pd_ff      <= nxt_pd;
      iso_ff     <= nxt_iso;
      restart_ff <= nxt_restart;
      dup_ff     <= nxt_dup;
      col_ff     <= nxt_col;
    end
  end

  // Read view
  wire [15:0] bmc_rd;
  assign bmc_rd[`PMC_B_SRST]    = ~srst_idle;
  assign bmc_rd[`PMC_B_LOOP]    = loop_ff;
  assign bmc_rd[`PMC_B_SPEED]   = spd_ff;
  assign bmc_rd[`PMC_B_AN_EN]   = an_ff;
  assign bmc_rd[`PMC_B_PDOWN]   = pd_ff;
  assign bmc_rd[`PMC_B_ISO]     = iso_ff;
  assign bmc_rd[`PMC_B_RESTART] = restart_ff;
  assign bmc_rd[`PMC_B_DUPLEX]  = dup_ff;
  assign bmc_rd[`PMC_B_COLTEST] = col_ff;
  assign bmc_rd[`PMC_RSVD_HI:0] = 7'h00;
  wire [15:0] rd_sel = addr_hit ? bmc_rd : `PMC_BMC_RST;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA  <= 16'h0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rd_sel;
      end
    end
  end

  // Port mode; negotiated results take over while auto-negotiation runs
  wire nxt_speed = an_ff ? AN_SPEED_100 : spd_ff;
  wire nxt_fdx   = an_ff ? AN_FULL_DUPLEX : dup_ff;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      SPEED_100   <= 1'b0;
      FULL_DUPLEX <= 1'b0;
      AN_ENABLE   <= 1'b0;
      AN_RESTART  <= 1'b0;
      POWER_DOWN  <= 1'b0;
      SOFT_RESET  <= 1'b0;
    end else begin
      SPEED_100   <= nxt_speed;
      FULL_DUPLEX <= nxt_fdx;
      AN_ENABLE   <= an_ff;
      AN_RESTART  <= rst_set;
      POWER_DOWN  <= pd_ff;
      SOFT_RESET  <= (nxt_state != SR_IDLE);
    end
  end

  // MII receive side
  wire       path_on = ~pd_ff & ~iso_ff & srst_idle & boot_done;
  wire [3:0] nxt_rxd = ~path_on ? 4'h0 : (loop_ff ? tx_d_s : LINE_RXD);
  wire       nxt_dv  = path_on & (loop_ff ? (tx_en_s & ~lb_t.busy) : LINE_RX_DV);
  // Test mode mirrors transmit enable; real collisions are meaningless in loopback
  wire       nxt_cl  = path_on & (col_ff ? tx_en_s : (~loop_ff & LINE_COL));

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      MII_OE    <= 1'b0;
      MII_RXD   <= 4'h0;
      MII_RX_DV <= 1'b0;
      MII_COL   <= 1'b0;
    end else begin
      MII_OE    <= ~iso_ff;
      MII_RXD   <= nxt_rxd;
      MII_RX_DV <= nxt_dv;
      MII_COL   <= nxt_cl;
    end
  end

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  sequence srst_req_s;
    srst_req;
  endsequence

  sequence srst_end_s;
    srst_t.done ##1 (state_ff == SR_RESTRAP);
  endsequence

  srst_hold_a: assert property (srst_req_s |=> SOFT_RESET [*8])
    else $error("Soft reset ended too early");

  srst_restrap_a: assert property (srst_end_s |=> an_ff == $past(strap_an)
    && spd_ff == $past(strap_spd) && dup_ff == $past(strap_dup) && !SOFT_RESET)
    else $error("Straps not reloaded after soft reset");

  srst_clear_a: assert property (srst_end_s |=> !loop_ff && !pd_ff && !iso_ff
    && !col_ff && !restart_ff)
    else $error("Control bits not cleared after soft reset");

  loop_data_a: assert property (path_on && loop_ff |=> MII_RXD == $past(tx_d_s))
    else $error("Loopback data mismatch");

  dead_time_a: assert property (lb_start |=> ##1 (!MII_RX_DV [*8]))
    else $error("Receive valid during loopback dead time");

  forced_mode_a: assert property (!an_ff |=> SPEED_100 == $past(spd_ff)
    && FULL_DUPLEX == $past(dup_ff))
    else $error("Forced speed or duplex not applied");

  an_mode_a: assert property (an_ff |=> SPEED_100 == $past(AN_SPEED_100)
    && FULL_DUPLEX == $past(AN_FULL_DUPLEX))
    else $error("Negotiated mode not applied");

  power_gate_a: assert property (pd_ff |=> !MII_RX_DV && !MII_COL && POWER_DOWN)
    else $error("Receive active in power down");

  iso_gate_a: assert property (iso_ff |=> !MII_OE && !MII_RX_DV)
    else $error("MII driven while isolated");

  restart_pulse_a: assert property (rst_set |=> AN_RESTART && restart_ff)
    else $error("Restart not issued");

  restart_ign_a: assert property (wr_hit && !wd[`PMC_B_AN_EN] |=> !AN_RESTART)
    else $error("Restart issued with negotiation off");

  restart_hold_a: assert property (restart_ff && !AN_STARTED && !load_cfg
    |=> restart_ff)
    else $error("Restart bit cleared before start");

  // Raise limit is too long for a delay range, so the wait is counted
  logic [10:0] col_wait_ff;
  wire         col_waiting = path_on & col_ff & tx_en_s & ~MII_COL;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      col_wait_ff <= 11'h000;
    end else if (!col_waiting) begin
      col_wait_ff <= 11'h000;
    end else if (col_wait_ff != 11'h7ff) begin
      col_wait_ff <= col_wait_ff + 11'h001;
    end
  end

  col_on_a: assert property (col_wait_ff <= 11'(COL_ON_MAX))
    else $error("Collision test did not raise COL");

  col_off_a: assert property (col_ff && $fell(tx_en_s)
    |-> ##[1:COL_OFF_MAX] !MII_COL)
    else $error("Collision test did not drop COL");

  rsvd_zero_a: assert property (REG_RVALID |-> REG_RDATA[6:0] == 7'h00)
    else $error("Reserved bits read nonzero");
endmodule

/* File: logic/pmc_cfg.svh */
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// Register map
`define PMC_BMC_OFFSET 5'h00
`define PMC_BMC_RST    16'h0000

// Field positions
`define PMC_B_SRST     15
`define PMC_B_LOOP     14
`define PMC_B_SPEED    13
`define PMC_B_AN_EN    12
`define PMC_B_PDOWN    11
`define PMC_B_ISO      10
`define PMC_B_RESTART  9
`define PMC_B_DUPLEX   8
`define PMC_B_COLTEST  7
`define PMC_RSVD_HI    6

// Timing
`define PMC_CLK_MHZ    250
`define PMC_SRST_NS    1000
`define PMC_LB_DEAD_US 500
`define PMC_BIT_NS     10
`define PMC_COL_ON_BT  512
`define PMC_COL_OFF_BT 4
`define PMC_BOOT_CYC   2'h3
`define PMC_SRST_CYC   ((`PMC_SRST_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_LB_DEAD_CYC (`PMC_LB_DEAD_US * `PMC_CLK_MHZ)
`define PMC_COL_ON_CYC ((`PMC_COL_ON_BT * `PMC_BIT_NS * `PMC_CLK_MHZ) / 1000)
`define PMC_COL_OFF_CYC ((`PMC_COL_OFF_BT * `PMC_BIT_NS * `PMC_CLK_MHZ) / 1000)

`endif

/* File: logic/pmc_pkg.sv */
package pmc_pkg;
  typedef enum logic [1:0] {SR_IDLE, SR_BUSY, SR_RESTRAP} pmc_srst_t;
  typedef logic [15:0] pmc_word_t;
endpackage

/* File: logic/pmc_timer.sv */
`timescale 1ns/100ps
module pmc_timer
  import pmc_pkg::*;
#(
  parameter int            CW   = 8,
  parameter logic [CW-1:0] LOAD = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  pmc_tmr_if.tmr   t
);
  // LOAD of zero wraps and runs 2**CW cycles; callers keep it at one or more
  logic [CW-1:0] cnt_ff;
  logic          busy_ff;
  logic          done_ff;
  wire           last = (cnt_ff == CW'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= busy_ff & last & ~t.start;
      if (t.start) begin
        cnt_ff  <= LOAD;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        cnt_ff  <= cnt_ff - CW'(1);
        busy_ff <= ~last;
      end
    end
  end

  assign t.busy = busy_ff;
  assign t.done = done_ff;
endmodule

/* File: logic/pmc_tmr_if.sv */
`timescale 1ns/100ps
interface pmc_tmr_if;
  logic start;
  logic busy;
  logic done;
  modport ctl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface

/* File: verification/phy_basic_mode_control_test.sv */
`timescale 1ns/100ps
module phy_basic_mode_control_test;
  import pmc_pkg::*;
  typedef struct {logic [15:0] wd; logic [15:0] rb; logic [8:0] o;} pmc_row_t;
  logic       CLOCK, RESETN, REG_WR, REG_RD, REG_RVALID;
  logic [4:0] REG_ADDR;
  pmc_word_t  REG_WDATA, REG_RDATA, d;
  logic       STRAP_AN_EN, STRAP_SPEED_100, STRAP_FULL_DUPLEX, MII_TX_EN;
  logic [3:0] MII_TXD, LINE_RXD, MII_RXD;
  logic       LINE_RX_DV, LINE_COL, AN_SPEED_100, AN_FULL_DUPLEX, AN_STARTED;
  logic       AN_ENABLE, AN_RESTART, SPEED_100, FULL_DUPLEX, POWER_DOWN;
  logic       SOFT_RESET, MII_OE, MII_RX_DV, MII_COL;
  int         err_count = 0;
  int         comparisons = 0;
  int         cycles = 0;
  int         restarts, starts;
  pmc_row_t   rows[8] = '{
    '{16'h2100, 16'h2100, 9'h1ba}, '{16'h0000, 16'h0000, 9'h03a},
    '{16'h207f, 16'h2000, 9'h13a}, '{16'h0800, 16'h0800, 9'h060},
    '{16'h0400, 16'h0400, 9'h000}, '{16'h0080, 16'h0080, 9'h03a},
    '{16'h0200, 16'h0000, 9'h03a}, '{16'h1100, 16'h1100, 9'h03a}};

  pmc_basic_ctrl #(.LB_DEAD_CYCLES(20), .SRST_CYCLES(10)) dut_u (
    .CLOCK(CLOCK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .STRAP_AN_EN(STRAP_AN_EN), .STRAP_SPEED_100(STRAP_SPEED_100),
    .STRAP_FULL_DUPLEX(STRAP_FULL_DUPLEX), .MII_TX_EN(MII_TX_EN), .MII_TXD(MII_TXD),
    .LINE_RXD(LINE_RXD), .LINE_RX_DV(LINE_RX_DV), .LINE_COL(LINE_COL),
    .AN_SPEED_100(AN_SPEED_100), .AN_FULL_DUPLEX(AN_FULL_DUPLEX), .AN_STARTED(AN_STARTED),
    .AN_ENABLE(AN_ENABLE), .AN_RESTART(AN_RESTART), .SPEED_100(SPEED_100),
    .FULL_DUPLEX(FULL_DUPLEX), .POWER_DOWN(POWER_DOWN), .SOFT_RESET(SOFT_RESET),
    .MII_OE(MII_OE), .MII_RXD(MII_RXD), .MII_RX_DV(MII_RX_DV), .MII_COL(MII_COL));
  pmc_an_model an_u (.clk(CLOCK), .restart(AN_RESTART), .started(AN_STARTED),
    .restarts(restarts), .starts(starts));

  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Bounded so a stuck run still reaches the report
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input pmc_word_t v);
    REG_ADDR = a;
    REG_WDATA = v;
    REG_WR = 1'b1;
    @(negedge CLOCK);
    REG_WR = 1'b0;
    // Let an edge pass so a following write never re-raises the strobe at once
    @(negedge CLOCK);
  endtask

  task automatic rd(input logic [4:0] a, output pmc_word_t v);
    int n;
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLOCK);
    REG_RD = 1'b0;
    n = 0;
    while (REG_RVALID !== 1'b1 && n < 4) begin
      @(negedge CLOCK);
      n++;
    end
    chk("read valid", 16'h1, {15'h0, REG_RVALID});
    v = REG_RDATA;
    @(negedge CLOCK);
  endtask

  task automatic rdchk(input logic [4:0] a, input pmc_word_t exp);
    pmc_word_t v;
    rd(a, v);
    chk("register word", exp, v);
  endtask

  task automatic wait_col(input logic exp, input int limit);
    int n;
    n = 0;
    while (MII_COL !== exp && n < limit) begin
      @(negedge CLOCK);
      n++;
    end
    chk("collision", {15'h0, exp}, {15'h0, MII_COL});
  endtask

  initial begin
    {RESETN, REG_WR, REG_RD, REG_ADDR, REG_WDATA, MII_TX_EN, MII_TXD} = '0;
    {STRAP_AN_EN, STRAP_SPEED_100, STRAP_FULL_DUPLEX} = 3'b010;
    {LINE_RXD, LINE_RX_DV, LINE_COL, AN_SPEED_100, AN_FULL_DUPLEX} = 8'ha8;
    repeat (2) @(negedge CLOCK);
    RESETN = 1'b1;
    repeat (5) @(negedge CLOCK);
    rdchk(5'h00, 16'h2000);
    wr(5'h01, 16'hffff);
    rdchk(5'h01, 16'h0000);
    rdchk(5'h00, 16'h2000);
    $display("test reset and unmapped done");

    foreach (rows[i]) begin
      wr(5'h00, rows[i].wd);
      rdchk(5'h00, rows[i].rb);
      chk("port outputs", {7'h0, rows[i].o}, {7'h0, SPEED_100, FULL_DUPLEX, POWER_DOWN,
        MII_OE, MII_RX_DV, MII_RXD});
    end
    chk("restart pulses", 16'h0, restarts[15:0]);
    $display("test table done");

    wr(5'h00, 16'h1200);
    rdchk(5'h00, 16'h1200);
    chk("negotiation enable", 16'h1, {15'h0, AN_ENABLE});
    wr(5'h00, 16'h1000);
    repeat (16) @(negedge CLOCK);
    chk("restart pulses", 16'h1, restarts[15:0]);
    chk("negotiation starts", 16'h1, starts[15:0]);
    rdchk(5'h00, 16'h1000);
    $display("test restart done");

    MII_TX_EN = 1'b1;
    MII_TXD = 4'h5;
    wr(5'h00, 16'h4100);
    repeat (5) @(negedge CLOCK);
    chk("dead time valid", 16'h0, {15'h0, MII_RX_DV});
    repeat (25) @(negedge CLOCK);
    chk("loopback data", 16'h15, {11'h0, MII_RX_DV, MII_RXD});
    MII_TX_EN = 1'b0;
    $display("test loopback done");

    wr(5'h00, 16'h0080);
    MII_TX_EN = 1'b1;
    wait_col(1'b1, 1280);
    MII_TX_EN = 1'b0;
    wait_col(1'b0, 10);
    $display("test collision done");

    {STRAP_AN_EN, STRAP_SPEED_100, STRAP_FULL_DUPLEX} = 3'b101;
    wr(5'h00, 16'hcc80);
    rd(5'h00, d);
    chk("reset bit", 16'h1, {15'h0, d[15]});
    chk("soft reset", 16'h1, {15'h0, SOFT_RESET});
    wr(5'h00, 16'h0800);
    for (int n = 0; n < 40 && SOFT_RESET !== 1'b0; n++) begin
      @(negedge CLOCK);
    end
    rdchk(5'h00, 16'h1100);
    $display("test soft reset done");
    summarize();
  end
endmodule

/* File: verification/pmc_an_model.sv */
`timescale 1ns/100ps
module pmc_an_model #(
  parameter int DELAY = 6
) (
  // Clock
  input  wire logic clk,
  // Engine handshake
  input  wire logic restart,
  output logic      started,
  // Event counts
  output int        restarts,
  output int        starts
);
  int cnt = 0;
  initial begin
    started = 1'b0;
    restarts = 0;
    starts = 0;
  end
  // Slow on purpose so the pending restart bit can be read back
  always @(posedge clk) begin
    started <= 1'b0;
    if (restart) begin
      restarts <= restarts + 1;
      cnt <= DELAY;
    end else if (cnt == 1) begin
      started <= 1'b1;
      starts <= starts + 1;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
